// ===== hw/srm_pkg.sv
// Package: register map, field masks and reset values of the special register bank
package srm_pkg;

    localparam int ADDR_W = 9;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [8:0] TIMER1_COUNT_LOW_ADDR = 9'h00c;
    localparam logic [8:0] TIMER1_COUNT_HIGH_ADDR = 9'h00d;
    localparam logic [8:0] TIMER1_CONTROL_ADDR = 9'h00e;
    localparam logic [8:0] TIMER2_COUNT_ADDR = 9'h00f;
    localparam logic [8:0] TIMER2_CONTROL_ADDR = 9'h010;
    localparam logic [8:0] TIMER2_PERIOD_ADDR = 9'h011;
    localparam logic [8:0] SLAVE_PHASE_SHIFT_LOW_ADDR = 9'h013;
    localparam logic [8:0] SLAVE_PHASE_SHIFT_HIGH_ADDR = 9'h014;
    localparam logic [8:0] PULSE_WIDTH_LOW_ADDR = 9'h015;
    localparam logic [8:0] PULSE_WIDTH_HIGH_ADDR = 9'h016;
    localparam logic [8:0] OUTPUT_VOLTAGE_COARSE_ADDR = 9'h019;
    localparam logic [8:0] OUTPUT_VOLTAGE_FINE_ADDR = 9'h01a;
    localparam logic [8:0] OSCILLATOR_TRIM_ADDR = 9'h01b;
    localparam logic [8:0] CONVERSION_RESULT_LOW_ADDR = 9'h01c;
    localparam logic [8:0] CONVERSION_RESULT_HIGH_ADDR = 9'h01d;
    localparam logic [8:0] CONVERTER_CONTROL_ADDR = 9'h01e;
    localparam logic [8:0] CONVERTER_CLOCK_SELECT_ADDR = 9'h01f;
    localparam logic [8:0] INDIRECT_ACCESS_PORT_ADDR = 9'h080;
    localparam logic [8:0] CORE_OPTIONS_ADDR = 9'h081;
    localparam logic [8:0] PROGRAM_COUNTER_LOW_ADDR = 9'h082;
    localparam logic [8:0] CORE_STATUS_ADDR = 9'h083;
    localparam logic [8:0] INDIRECT_POINTER_ADDR = 9'h084;
    localparam logic [8:0] PORT_A_DIRECTION_ADDR = 9'h085;
    localparam logic [8:0] PORT_B_DIRECTION_ADDR = 9'h086;
    localparam logic [8:0] PERIPHERAL_IRQ_ENABLE_ONE_ADDR = 9'h087;
    localparam logic [8:0] PERIPHERAL_IRQ_ENABLE_TWO_ADDR = 9'h088;
    localparam logic [8:0] ALTERNATE_PIN_FUNCTION_ADDR = 9'h089;
    localparam logic [8:0] PROGRAM_COUNTER_UPPER_LATCH_ADDR = 9'h08a;
    // Pin change block and interrupt status/mask
    localparam logic [8:0] PIN_CHANGE_CONTROL_ADDR = 9'h08b;
    localparam logic [8:0] IRQ_STATUS_ADDR = 9'h08c;
    localparam logic [8:0] IRQ_MASK_ADDR = 9'h08d;

    // ------------------------------------------------------------
    // Implemented bit masks
    // ------------------------------------------------------------
    localparam logic [7:0] TIMER1_CONTROL_MASK = 8'h33;
    localparam logic [7:0] TIMER2_CONTROL_MASK = 8'h07;
    localparam logic [7:0] OUTPUT_VOLTAGE_FINE_MASK = 8'h9f;
    localparam logic [7:0] OSCILLATOR_TRIM_MASK = 8'h1f;
    localparam logic [7:0] CONVERSION_RESULT_HIGH_MASK = 8'h03;
    localparam logic [7:0] CONVERTER_CONTROL_MASK = 8'h7f;
    localparam logic [7:0] CONVERTER_CLOCK_SELECT_MASK = 8'h70;
    localparam logic [7:0] PORT_B_DIRECTION_MASK = 8'hf7;
    localparam logic [7:0] PERIPHERAL_IRQ_ENABLE_ONE_MASK = 8'h73;
    localparam logic [7:0] PERIPHERAL_IRQ_ENABLE_TWO_MASK = 8'hb3;
    localparam logic [7:0] ALTERNATE_PIN_FUNCTION_MASK = 8'h01;
    localparam logic [7:0] PROGRAM_COUNTER_UPPER_LATCH_MASK = 8'h1f;
    // Status: bank select, flags writable; timeout/power-down flags read-only
    localparam logic [7:0] CORE_STATUS_WRITE_MASK = 8'he7;
    localparam int STATUS_INDIRECT_BANK_SELECT_HIGH_BIT = 7;
    localparam int STATUS_DIRECT_BANK_SELECT_HIGH_BIT = 6;
    localparam int STATUS_TIMEOUT_BIT = 4;
    localparam int STATUS_POWER_DOWN_BIT = 3;
    // Pin change control: bit 0 enable, bit 1 flag (write 0 clears)
    localparam int PIN_CHANGE_ENABLE_BIT = 0;
    localparam int PIN_CHANGE_FLAG_BIT = 1;
    localparam int IRQ_PIN_CHANGE_BIT = 0;
    localparam int IRQ_TIMEOUT_BIT = 1;
    localparam logic [7:0] IRQ_MASK_IMPL = 8'h03;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ZERO_RESET = 8'h00;
    localparam logic [7:0] ONES_RESET = 8'hff;
    localparam logic [7:0] CORE_STATUS_POR_RESET = 8'h18;
    localparam logic [7:0] UNKNOWN_RESET = 8'h00;

    typedef enum logic [1:0] {
        SRM_RST_NONE = 2'b00,
        SRM_RST_POWER_ON = 2'b01,
        SRM_RST_OTHER = 2'b11
    } srm_reset_kind_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic write;
        logic read;
    } srm_bus_req_t;

    typedef struct packed {
        logic [7:0] timer1CountLow;
        logic [7:0] timer1CountHigh;
        logic [7:0] timer1Control;
        logic [7:0] timer2Count;
        logic [7:0] timer2Control;
        logic [7:0] timer2Period;
        logic [7:0] slavePhaseShiftLow;
        logic [7:0] slavePhaseShiftHigh;
        logic [7:0] pulseWidthLow;
        logic [7:0] pulseWidthHigh;
        logic [7:0] outputVoltageCoarse;
        logic [7:0] outputVoltageFine;
        logic [7:0] oscillatorTrim;
        logic [7:0] conversionResultLow;
        logic [7:0] conversionResultHigh;
        logic [7:0] converterControl;
        logic [7:0] converterClockSelect;
        logic [7:0] coreOptions;
        logic [7:0] programCounterLow;
        logic [7:0] coreStatus;
        logic [7:0] indirectPointer;
        logic [7:0] portADirection;
        logic [7:0] portBDirection;
        logic [7:0] peripheralIrqEnableOne;
        logic [7:0] peripheralIrqEnableTwo;
        logic [7:0] alternatePinFunction;
        logic [7:0] programCounterUpperLatch;
        logic [7:0] previousPins;
        logic pinChangeEnable;
        logic pin_change_flag;
        logic [7:0] irqStatus;
        logic [7:0] irqMask;
        logic [7:0] rdata;
    } srm_state_t;

endpackage : srm_pkg

// ===== hw/srm_special_registers.sv
// Special register bank with power-on and other reset classes
// Behaviour
// - Unimplemented locations and unimplemented bits read back as zero.
// - The other reset class is master clear or watchdog reset, and unchanged bits keep their value.
// - Master clear and watchdog resets leave the pin change previous-value latch untouched.
// - The pin change flag clears on reset and sets again while a pin mismatch remains.
`timescale 1ns/1ps
module srm_special_registers
    import srm_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic external_master_clear,
    input wire logic watchdog_timer_reset,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    input wire logic [7:0] pinState,
    input wire logic [7:0] indirectReadData,
    output logic [7:0] rdata,
    output logic indirectWrite,
    output logic [7:0] indirectWriteData,
    output logic [7:0] indirectAddress,
    output logic [7:0] portADirection,
    output logic [7:0] portBDirection,
    output logic pin_change_flag,
    output logic irq
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] srm_keep(input logic [7:0] oldv, input logic [7:0] newv,
                                            input logic [7:0] mask);
        srm_keep = (newv & mask) | (oldv & ~mask);
    endfunction : srm_keep

    srm_state_t st;
    srm_state_t next_st;
    srm_bus_req_t req;
    srm_reset_kind_t rstKind;
    logic otherReset;
    logic [7:0] mismatch;

    assign req = '{addr: addr, wdata: wdata, write: writeStrobe, read: readStrobe};
    assign otherReset = external_master_clear | watchdog_timer_reset;
    assign rstKind = !resetn ? SRM_RST_POWER_ON : (otherReset ? SRM_RST_OTHER : SRM_RST_NONE);
    assign mismatch = pinState ^ st.previousPins;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] rd;
        logic [7:0] irqSet;
        logic doRead;
        logic doWrite;
        rd = 8'h00;
        irqSet = 8'h00;
        next_st = st;
        doRead = req.read && (rstKind == SRM_RST_NONE);
        doWrite = req.write && (rstKind == SRM_RST_NONE);

        unique case (rstKind)
            SRM_RST_POWER_ON: begin
                next_st.timer1CountLow = UNKNOWN_RESET;
                next_st.timer1CountHigh = UNKNOWN_RESET;
                next_st.timer1Control = ZERO_RESET;
                next_st.timer2Count = ZERO_RESET;
                next_st.timer2Control = ZERO_RESET;
                next_st.timer2Period = ONES_RESET;
                next_st.slavePhaseShiftLow = UNKNOWN_RESET;
                next_st.slavePhaseShiftHigh = UNKNOWN_RESET;
                next_st.pulseWidthLow = UNKNOWN_RESET;
                next_st.pulseWidthHigh = UNKNOWN_RESET;
                next_st.outputVoltageCoarse = ZERO_RESET;
                next_st.outputVoltageFine = ZERO_RESET;
                next_st.oscillatorTrim = ZERO_RESET;
                next_st.conversionResultLow = UNKNOWN_RESET;
                next_st.conversionResultHigh = UNKNOWN_RESET;
                next_st.converterControl = ZERO_RESET;
                next_st.converterClockSelect = ZERO_RESET;
                next_st.coreOptions = ONES_RESET;
                next_st.programCounterLow = ZERO_RESET;
                next_st.coreStatus = CORE_STATUS_POR_RESET;
                next_st.indirectPointer = UNKNOWN_RESET;
                next_st.portADirection = ONES_RESET;
                next_st.portBDirection = ONES_RESET & PORT_B_DIRECTION_MASK;
                next_st.peripheralIrqEnableOne = ZERO_RESET;
                next_st.peripheralIrqEnableTwo = ZERO_RESET;
                next_st.alternatePinFunction = ZERO_RESET;
                next_st.programCounterUpperLatch = ZERO_RESET;
                next_st.previousPins = ZERO_RESET;
                next_st.pinChangeEnable = 1'b0;
                next_st.pin_change_flag = 1'b0;
                next_st.irqStatus = ZERO_RESET;
                next_st.irqMask = ZERO_RESET;
                next_st.rdata = ZERO_RESET;
            end
            SRM_RST_OTHER: begin
                // Timer counts, pointers and pulse registers stay as they were
                next_st.timer1Control = st.timer1Control;
                next_st.timer2Control = ZERO_RESET;
                next_st.timer2Period = ONES_RESET;
                next_st.outputVoltageCoarse = ZERO_RESET;
                next_st.outputVoltageFine = ZERO_RESET;
                next_st.oscillatorTrim = ZERO_RESET;
                next_st.converterControl = ZERO_RESET;
                next_st.converterClockSelect = ZERO_RESET;
                next_st.coreOptions = ONES_RESET;
                next_st.programCounterLow = ZERO_RESET;
                // Bank selects cleared, timeout by cause, power-down always set, flags kept
                next_st.coreStatus = {3'b000, ~watchdog_timer_reset, 1'b1, st.coreStatus[2:0]};
                next_st.portADirection = ONES_RESET;
                next_st.portBDirection = ONES_RESET & PORT_B_DIRECTION_MASK;
                next_st.peripheralIrqEnableOne = ZERO_RESET;
                next_st.peripheralIrqEnableTwo = ZERO_RESET;
                next_st.alternatePinFunction = ZERO_RESET;
                next_st.programCounterUpperLatch = ZERO_RESET;
                next_st.previousPins = st.previousPins;
                next_st.pin_change_flag = 1'b0;
                next_st.rdata = ZERO_RESET;
                if (watchdog_timer_reset) begin
                    next_st.irqStatus = st.irqStatus | (8'h01 << IRQ_TIMEOUT_BIT);
                end
            end
            SRM_RST_NONE: begin
                // Read mux; unmapped addresses and bits give zero
                if (doRead) begin
                    unique case (req.addr)
                        TIMER1_COUNT_LOW_ADDR: rd = st.timer1CountLow;
                        TIMER1_COUNT_HIGH_ADDR: rd = st.timer1CountHigh;
                        TIMER1_CONTROL_ADDR: rd = st.timer1Control;
                        TIMER2_COUNT_ADDR: rd = st.timer2Count;
                        TIMER2_CONTROL_ADDR: rd = st.timer2Control;
                        TIMER2_PERIOD_ADDR: rd = st.timer2Period;
                        SLAVE_PHASE_SHIFT_LOW_ADDR: rd = st.slavePhaseShiftLow;
                        SLAVE_PHASE_SHIFT_HIGH_ADDR: rd = st.slavePhaseShiftHigh;
                        PULSE_WIDTH_LOW_ADDR: rd = st.pulseWidthLow;
                        PULSE_WIDTH_HIGH_ADDR: rd = st.pulseWidthHigh;
                        OUTPUT_VOLTAGE_COARSE_ADDR: rd = st.outputVoltageCoarse;
                        OUTPUT_VOLTAGE_FINE_ADDR: rd = st.outputVoltageFine;
                        OSCILLATOR_TRIM_ADDR: rd = st.oscillatorTrim;
                        CONVERSION_RESULT_LOW_ADDR: rd = st.conversionResultLow;
                        CONVERSION_RESULT_HIGH_ADDR: rd = st.conversionResultHigh;
                        CONVERTER_CONTROL_ADDR: rd = st.converterControl;
                        CONVERTER_CLOCK_SELECT_ADDR: rd = st.converterClockSelect;
                        INDIRECT_ACCESS_PORT_ADDR: rd = indirectReadData;
                        CORE_OPTIONS_ADDR: rd = st.coreOptions;
                        PROGRAM_COUNTER_LOW_ADDR: rd = st.programCounterLow;
                        CORE_STATUS_ADDR: rd = st.coreStatus;
                        INDIRECT_POINTER_ADDR: rd = st.indirectPointer;
                        PORT_A_DIRECTION_ADDR: rd = st.portADirection;
                        PORT_B_DIRECTION_ADDR: rd = st.portBDirection;
                        PERIPHERAL_IRQ_ENABLE_ONE_ADDR: rd = st.peripheralIrqEnableOne;
                        PERIPHERAL_IRQ_ENABLE_TWO_ADDR: rd = st.peripheralIrqEnableTwo;
                        ALTERNATE_PIN_FUNCTION_ADDR: rd = st.alternatePinFunction;
                        PROGRAM_COUNTER_UPPER_LATCH_ADDR: rd = st.programCounterUpperLatch;
                        PIN_CHANGE_CONTROL_ADDR: rd = {6'h00, st.pin_change_flag, st.pinChangeEnable};
                        IRQ_STATUS_ADDR: rd = st.irqStatus;
                        IRQ_MASK_ADDR: rd = st.irqMask;
                        default: rd = 8'h00;
                    endcase
                end
                next_st.rdata = rd;

                if (doWrite) begin
                    unique case (req.addr)
                        TIMER1_COUNT_LOW_ADDR: next_st.timer1CountLow = req.wdata;
                        TIMER1_COUNT_HIGH_ADDR: next_st.timer1CountHigh = req.wdata;
                        TIMER1_CONTROL_ADDR: next_st.timer1Control = req.wdata & TIMER1_CONTROL_MASK;
                        TIMER2_COUNT_ADDR: next_st.timer2Count = req.wdata;
                        TIMER2_CONTROL_ADDR: next_st.timer2Control = req.wdata & TIMER2_CONTROL_MASK;
                        TIMER2_PERIOD_ADDR: next_st.timer2Period = req.wdata;
                        SLAVE_PHASE_SHIFT_LOW_ADDR: next_st.slavePhaseShiftLow = req.wdata;
                        SLAVE_PHASE_SHIFT_HIGH_ADDR: next_st.slavePhaseShiftHigh = req.wdata;
                        PULSE_WIDTH_LOW_ADDR: next_st.pulseWidthLow = req.wdata;
                        PULSE_WIDTH_HIGH_ADDR: next_st.pulseWidthHigh = req.wdata;
                        OUTPUT_VOLTAGE_COARSE_ADDR: next_st.outputVoltageCoarse = req.wdata;
                        OUTPUT_VOLTAGE_FINE_ADDR:
                            next_st.outputVoltageFine = req.wdata & OUTPUT_VOLTAGE_FINE_MASK;
                        OSCILLATOR_TRIM_ADDR: next_st.oscillatorTrim = req.wdata & OSCILLATOR_TRIM_MASK;
                        CONVERSION_RESULT_LOW_ADDR: next_st.conversionResultLow = req.wdata;
                        CONVERSION_RESULT_HIGH_ADDR:
                            next_st.conversionResultHigh = req.wdata & CONVERSION_RESULT_HIGH_MASK;
                        CONVERTER_CONTROL_ADDR:
                            next_st.converterControl = req.wdata & CONVERTER_CONTROL_MASK;
                        CONVERTER_CLOCK_SELECT_ADDR:
                            next_st.converterClockSelect = req.wdata & CONVERTER_CLOCK_SELECT_MASK;
                        CORE_OPTIONS_ADDR: next_st.coreOptions = req.wdata;
                        PROGRAM_COUNTER_LOW_ADDR: next_st.programCounterLow = req.wdata;
                        // Reserved bank bits are stored as written; software keeps them clear
                        CORE_STATUS_ADDR:
                            next_st.coreStatus = srm_keep(st.coreStatus, req.wdata,
                                                          CORE_STATUS_WRITE_MASK);
                        INDIRECT_POINTER_ADDR: next_st.indirectPointer = req.wdata;
                        PORT_A_DIRECTION_ADDR: next_st.portADirection = req.wdata;
                        PORT_B_DIRECTION_ADDR:
                            next_st.portBDirection = req.wdata & PORT_B_DIRECTION_MASK;
                        PERIPHERAL_IRQ_ENABLE_ONE_ADDR:
                            next_st.peripheralIrqEnableOne = req.wdata & PERIPHERAL_IRQ_ENABLE_ONE_MASK;
                        PERIPHERAL_IRQ_ENABLE_TWO_ADDR:
                            next_st.peripheralIrqEnableTwo = req.wdata & PERIPHERAL_IRQ_ENABLE_TWO_MASK;
                        ALTERNATE_PIN_FUNCTION_ADDR:
                            next_st.alternatePinFunction = req.wdata & ALTERNATE_PIN_FUNCTION_MASK;
                        PROGRAM_COUNTER_UPPER_LATCH_ADDR:
                            next_st.programCounterUpperLatch =
                                req.wdata & PROGRAM_COUNTER_UPPER_LATCH_MASK;
                        PIN_CHANGE_CONTROL_ADDR: begin
                            next_st.pinChangeEnable = req.wdata[PIN_CHANGE_ENABLE_BIT];
                            if (!req.wdata[PIN_CHANGE_FLAG_BIT]) begin
                                next_st.pin_change_flag = 1'b0;
                            end
                        end
                        IRQ_MASK_ADDR: next_st.irqMask = req.wdata & IRQ_MASK_IMPL;
                        default: ;
                    endcase
                end

                // Reading the pin port refreshes the latch; here it is sampled on a read of
                // the pin change control register while the enable is set
                if (st.pinChangeEnable && doRead && req.addr == PIN_CHANGE_CONTROL_ADDR) begin
                    next_st.previousPins = pinState;
                end

                // Mismatch sets flag, winning over a clear in the same cycle
                if (mismatch != 8'h00) begin
                    next_st.pin_change_flag = 1'b1;
                    irqSet[IRQ_PIN_CHANGE_BIT] = 1'b1;
                end
                if (doRead && req.addr == IRQ_STATUS_ADDR) begin
                    next_st.irqStatus = irqSet;
                end else begin
                    next_st.irqStatus = st.irqStatus | irqSet;
                end
            end
            default: ;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn || clkEn) begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    // Frozen cycles take no write, so no pulse leaves the block then either
    assign indirectWrite = writeStrobe && addr == INDIRECT_ACCESS_PORT_ADDR && resetn
                           && !otherReset && clkEn;
    assign indirectWriteData = wdata;
    assign indirectAddress = st.indirectPointer;
    assign portADirection = st.portADirection;
    assign portBDirection = st.portBDirection;
    assign pin_change_flag = st.pin_change_flag;
    assign irq = |(st.irqStatus & st.irqMask);

endmodule : srm_special_registers

// ===== tb/srm_properties.sv
// Checker: port-level properties of the special register bank
`timescale 1ns/1ps
module srm_properties
    import srm_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic external_master_clear,
    input wire logic watchdog_timer_reset,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic readStrobe,
    input wire logic [7:0] rdata,
    input wire logic [7:0] indirectAddress,
    input wire logic [7:0] portADirection,
    input wire logic [7:0] portBDirection,
    input wire logic pin_change_flag
);
    wire logic otherRst = resetn && clkEn && (external_master_clear || watchdog_timer_reset);
    wire logic gapRead = readStrobe && clkEn && !otherRst && addr inside {9'h012, 9'h017, 9'h018};

    idle_read_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        !readStrobe |=> rdata == 8'h00) else $error("read data not zero when idle");
    unmapped_read_a: assert property (@(posedge clk) disable iff (!resetn)
        gapRead |=> rdata == 8'h00) else $error("unmapped location read nonzero");
    por_values_a: assert property (@(posedge clk)
        !resetn |=> portADirection == ONES_RESET && portBDirection == PORT_B_DIRECTION_MASK)
        else $error("direction registers wrong after power-on reset");
    other_values_a: assert property (@(posedge clk) disable iff (!resetn)
        otherRst |=> portADirection == ONES_RESET) else $error("direction wrong after other reset");
    pointer_kept_a: assert property (@(posedge clk) disable iff (!resetn)
        otherRst |=> $stable(indirectAddress)) else $error("pointer changed by other reset");
    flag_cleared_a: assert property (@(posedge clk) disable iff (!resetn)
        otherRst |=> !pin_change_flag) else $error("pin change flag kept over reset");
endmodule : srm_properties

// ===== tb/testbench.sv
// Testbench: register access, reset classes, pin change and interrupt tests
`timescale 1ns/1ps
module testbench
    import srm_pkg::*;
;
    logic clk = 0, resetn = 0, clkEn = 1, masterClear = 0, watchdogReset = 0, wrS = 0, rdS = 0;
    logic irq, flag, iw;
    logic [8:0] addr = 9'h000;
    logic [7:0] wdata = 8'h00, pinState = 8'h3c, rdata, pointerOut, iwd, v;
    int err_count = 0, num_checks = 0;
    logic [8:0] ra [8] = '{9'h011, 9'h081, 9'h085, 9'h086, 9'h010, 9'h08a, 9'h083, 9'h01f};
    logic [7:0] rv [8] = '{8'hff, 8'hff, 8'hff, 8'hf7, 8'h00, 8'h00, 8'h18, 8'h00};

    srm_special_registers i_dut(.clk(clk), .resetn(resetn), .clkEn(clkEn),
        .external_master_clear(masterClear), .watchdog_timer_reset(watchdogReset), .addr(addr),
        .wdata(wdata), .writeStrobe(wrS), .readStrobe(rdS), .pinState(pinState),
        .indirectReadData(8'ha5), .rdata(rdata), .indirectWrite(iw), .indirectWriteData(iwd),
        .indirectAddress(pointerOut), .portADirection(), .portBDirection(),
        .pin_change_flag(flag), .irq(irq));

    initial begin
        forever #50 clk = ~clk;
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
            err_count++;
        end
    endtask : check

    task wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wrS <= 1'b1;
        @(posedge clk);
        wrS <= 1'b0;
    endtask : wr

    task rd(input logic [8:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a; rdS <= 1'b1;
        @(posedge clk);
        rdS <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd

    // Hold one cycle; the bus is ignored meanwhile
    task oreset(input logic w);
        @(posedge clk);
        if (w) watchdogReset <= 1'b1; else masterClear <= 1'b1;
        @(posedge clk);
        watchdogReset <= 1'b0; masterClear <= 1'b0;
        @(negedge clk);
    endtask : oreset

    task complete_run();
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run

    initial begin
        #400000;
        err_count++;
        complete_run();
    end

    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        foreach (ra[i]) begin rd(ra[i], v); check(v, rv[i]); end
        $display("done power-on values");
        wr(9'h012, 8'h5a); rd(9'h012, v); check(v, 8'h00);
        rd(9'h017, v); check(v, 8'h00);
        wr(9'h010, 8'hff); rd(9'h010, v); check(v, 8'h07);
        wr(9'h089, 8'hff); rd(9'h089, v); check(v, 8'h01);
        $display("done unimplemented reads");
        // Latch the pins first so the power-on mismatch stops feeding the status
        wr(9'h08b, 8'h01); rd(9'h08b, v); check(v, 8'h03);
        rd(9'h08c, v); check(v, 8'h01);
        oreset(1'b1); check({7'h00, irq}, 8'h00);
        wr(9'h08d, 8'h02); @(negedge clk); check({7'h00, irq}, 8'h01);
        rd(9'h08c, v); check(v, 8'h02); check({7'h00, irq}, 8'h00);
        rd(9'h08c, v); check(v, 8'h00);
        wr(9'h08d, 8'h00);
        $display("done interrupt");
        wr(9'h084, 8'h5a); wr(9'h083, 8'h07);
        wr(9'h085, 8'h00); wr(9'h011, 8'h10);
        oreset(1'b0); check(pointerOut, 8'h5a);
        rd(9'h083, v); check(v, 8'h1f);
        rd(9'h085, v); check(v, 8'hff);
        rd(9'h011, v); check(v, 8'hff);
        rd(9'h010, v); check(v, 8'h00);
        oreset(1'b1); rd(9'h083, v); check(v, 8'h0f);
        $display("done other resets");
        rd(9'h080, v); check(v, 8'ha5);
        @(posedge clk);
        addr <= 9'h080;
        wdata <= 8'h3e;
        wrS <= 1'b1;
        @(negedge clk);
        check({7'h00, iw}, 8'h01);
        check(iwd, 8'h3e);
        @(posedge clk);
        wrS <= 1'b0;
        clkEn <= 1'b0;
        @(posedge clk);
        wrS <= 1'b1;
        @(negedge clk);
        check({7'h00, iw}, 8'h00);
        @(posedge clk);
        addr <= 9'h011;
        wdata <= 8'h42;
        @(posedge clk);
        wrS <= 1'b0;
        clkEn <= 1'b1;
        rd(9'h011, v); check(v, 8'hff);
        $display("done indirect and clock enable");
        wr(9'h08b, 8'h01); rd(9'h08b, v); wr(9'h08b, 8'h01);
        repeat (2) @(negedge clk); check({7'h00, flag}, 8'h00);
        @(posedge clk);
        pinState <= 8'h3d; repeat (2) @(negedge clk); check({7'h00, flag}, 8'h01);
        oreset(1'b0); check({7'h00, flag}, 8'h00);
        @(posedge clk);
        pinState <= 8'h3c;
        @(negedge clk); check({7'h00, flag}, 8'h01);
        wr(9'h08b, 8'h01);
        repeat (2) @(negedge clk); check({7'h00, flag}, 8'h00);
        @(posedge clk);
        pinState <= 8'h3d; repeat (2) @(negedge clk); check({7'h00, flag}, 8'h01);
        $display("done pin change");
        complete_run();
    end
endmodule : testbench

bind srm_special_registers srm_properties i_props(.clk(clk), .resetn(resetn), .clkEn(clkEn),
    .external_master_clear(external_master_clear), .watchdog_timer_reset(watchdog_timer_reset),
    .addr(addr), .readStrobe(readStrobe), .rdata(rdata), .indirectAddress(indirectAddress),
    .portADirection(portADirection), .portBDirection(portBDirection),
    .pin_change_flag(pin_change_flag));
